// ---- angle_sensor_spi_slave_test.sv ----
module angle_sensor_spi_slave_test;
  import asp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int RES = 12;        // useful angle bits of both devices
  localparam int NVM = 40;        // shortened store update time
  localparam int HALF  = 4;       // system cycles per half serial clock
  localparam int EARLY = 2;       // store wait that pair 1 cuts short

  logic              sys_clk;
  logic              rst_b;
  logic              start;
  asp_op_t           op;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [WORD_W-1:0] angle;
  logic              fh;
  logic              fl;
  logic [1:0]        busy;
  logic [1:0]        done;
  logic [1:0]        dir;
  logic [WORD_W-1:0] rdata [2];
  int                error_cnt;
  int                checks_done;
  logic [WORD_W-1:0] mask;

  asp_spi_if link0 ();
  asp_spi_if link1 ();

  // pair 0: mode 0, host keeps the store wait
  asp_spi_host #(.SCLK_HALF(HALF), .MODE3(1'b0), .NVM_WAIT(NVM)) u_asp_spi_host (
    .I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_START(start), .I_OP(op), .I_ADDR(addr),
    .I_WDATA(wdata), .O_BUSY(busy[0]), .O_DONE(done[0]), .O_RDATA(rdata[0]), .LINK(link0));
  asp_spi_dev #(.ANGLE_RES(RES), .NVM_WAIT(NVM)) u_asp_spi_dev (
    .I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_ANGLE(angle), .I_FIELD_HIGH(fh),
    .I_FIELD_LOW(fl), .O_DIR_CCW(dir[0]), .LINK(link0));
  // pair 1: mode 3, host cuts the store wait short on purpose
  asp_spi_host #(.SCLK_HALF(HALF), .MODE3(1'b1), .NVM_WAIT(EARLY)) u_asp_spi_host_m3 (
    .I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_START(start), .I_OP(op), .I_ADDR(addr),
    .I_WDATA(wdata), .O_BUSY(busy[1]), .O_DONE(done[1]), .O_RDATA(rdata[1]), .LINK(link1));
  asp_spi_dev #(.ANGLE_RES(RES), .NVM_WAIT(NVM)) u_asp_spi_dev_m3 (
    .I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_ANGLE(angle), .I_FIELD_HIGH(fh),
    .I_FIELD_LOW(fl), .O_DIR_CCW(dir[1]), .LINK(link1));

  asp_link_chk #(.MODE3(1'b0)) u_asp_link_chk (
    .I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .sclk(link0.sclk), .cs_n(link0.cs_n),
    .mosi(link0.mosi), .miso(link0.miso), .miso_oe_n(link0.miso_oe_n), .miso_line(link0.miso_line));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // both hosts take the same request; wait until each has finished
  task automatic run_op(input asp_op_t o, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [1:0] seen;
    seen = 2'b00;
    @(negedge sys_clk);
    op = o;
    addr = a;
    wdata = d;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    chk({14'h0000, busy}, 16'h0003);
    for (int i = 0; i < 3000 && seen != 2'b11; i++) begin
      @(negedge sys_clk);
      seen = seen | done;
    end
    chk({14'h0000, busy}, 16'h0000);
    if (seen != 2'b11) begin
      $display("FAIL t=%0t got=%h exp=%h", $time, seen, 2'h3);
      error_cnt++;
    end
  endtask

  // full read, low positions padded with zeros, both clock modes
  task automatic t_angle;
    angle = 16'hbeef;
    repeat (12) @(negedge sys_clk);
    run_op(ASP_OP_ANGLE, 5'h00, 8'h00);
    chk(rdata[0], 16'hbeef & mask);
    chk(rdata[1], 16'hbeef & mask);
  endtask

  // a new angle arriving mid-frame must not reach that frame
  task automatic t_freeze;
    angle = 16'h1234;
    repeat (12) @(negedge sys_clk);
    fork
      run_op(ASP_OP_ANGLE, 5'h00, 8'h00);
      begin
        repeat (40) @(negedge sys_clk);
        angle = 16'h5678;
      end
    join
    chk(rdata[0], 16'h1234 & mask);
    run_op(ASP_OP_ANGLE, 5'h00, 8'h00);
    chk(rdata[0], 16'h5678 & mask);
    run_op(ASP_OP_ANGLE, 5'h00, 8'h00);
    chk(rdata[1], 16'h5678 & mask);
  endtask

  // factory contents come back in the upper byte
  task automatic t_factory;
    logic [ADDR_W-1:0] na [5];
    logic [DATA_W-1:0] nv [5];
    na = '{5'h04, 5'h05, 5'h06, 5'h09, 5'h00};
    nv = '{8'hc0, 8'hff, 8'h1c, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      run_op(ASP_OP_READ, na[i], 8'h00);
      chk(rdata[0], {nv[i], 8'h00});
    end
  endtask

  // every combination of the two field flags
  task automatic t_flags;
    for (int k = 0; k < 4; k++) begin
      @(negedge sys_clk);
      fh = k[1];
      fl = k[0];
      repeat (4) @(negedge sys_clk);
      run_op(ASP_OP_READ, ADDR_FLAGS, 8'h00);
      chk(rdata[0], {k[1], k[0], 14'h0000});
      chk(rdata[1], {k[1], k[0], 14'h0000});
    end
  endtask

  // pair 0 waits and sees the new value, pair 1 is early and sees the old
  task automatic t_write;
    run_op(ASP_OP_WRITE, ADDR_DIR, 8'h80);
    chk(rdata[0], 16'h8000);
    chk(rdata[1], 16'h0000);
    repeat (NVM) @(negedge sys_clk);
    chk({15'h0000, dir[0]}, 16'h0001);
    chk({15'h0000, dir[1]}, 16'h0001);
    run_op(ASP_OP_READ, ADDR_DIR, 8'h00);
    chk(rdata[0], 16'h8000);
    chk(rdata[1], 16'h8000);
  endtask

  // watchdog sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  initial begin
    mask = 16'hffff << (WORD_W - RES);
    error_cnt = 0;
    checks_done = 0;
    rst_b = 1'b1;
    start = 1'b0;
    op = ASP_OP_ANGLE;
    addr = 5'h00;
    wdata = 8'h00;
    angle = 16'h0000;
    fh = 1'b0;
    fl = 1'b0;
    // a real falling edge once every process waits, so the link-side reset is not lost at time zero
    #1;
    rst_b = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_b = 1'b1;
    t_angle();
    t_freeze();
    t_factory();
    t_flags();
    t_write();
    end_of_test();
  end
endmodule

// ---- asp_link_chk.sv ----
module asp_link_chk
  import asp_pkg::*;
#(
  parameter bit MODE3 = 1'b0        // clock idle level of the watched host
) (
  input wire logic I_SYS_CLK,       // system clock
  input wire logic I_RST_B,         // sync reset, active low
  input wire logic sclk,            // serial clock
  input wire logic cs_n,            // select, active low
  input wire logic mosi,            // host data
  input wire logic miso,            // device data before the pin
  input wire logic miso_oe_n,       // device output enable, active low
  input wire logic miso_line        // resolved data-out pin
);
  timeunit 1ns;
  timeprecision 1ns;

  logic              sclk_r;
  logic [4:0]        cnt_r;
  logic [WORD_W-1:0] cmd_r;
  logic              rise;

  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);

  // rising serial edges seen in the system domain; host makes sclk there
  assign rise = sclk & ~sclk_r;

  always_ff @(posedge I_SYS_CLK) begin
    sclk_r <= I_RST_B ? sclk : 1'b0;
  end

  // edge count per frame, cleared only while deselected so it survives the rise
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B || cs_n) begin
      cnt_r <= 5'h00;
    end else if (rise) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // command word as the device would capture it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cmd_r <= 16'h0000;
    end else if (rise && !cs_n) begin
      cmd_r <= {cmd_r[WORD_W-2:0], mosi};
    end
  end

  sequence s_frame_end;
    $rose(cs_n);
  endsequence

  sequence s_reg_end;
    s_frame_end ##0 (cmd_r[OP_MSB:OP_LSB] == OP_READ || cmd_r[OP_MSB:OP_LSB] == OP_WRITE);
  endsequence

  a_oe_follows_cs: assert property (miso_oe_n == cs_n)
    else $error("data-out enable does not follow select");
  a_clock_idle_lvl: assert property ((cs_n && $past(cs_n)) |-> sclk == MODE3)
    else $error("serial clock not at idle level outside a frame");
  a_frame_sixteen_edges: assert property (s_frame_end |-> cnt_r == 5'h10)
    else $error("frame without exactly sixteen rising edges");
  a_mosi_hold_high: assert property ((!cs_n && sclk && $past(sclk)) |-> $stable(mosi))
    else $error("host data changed while clock high");
  a_miso_hold_high: assert property ((!cs_n && sclk && $past(sclk)) |-> $stable(miso_line))
    else $error("device data changed while clock high");
  a_miso_hold_dev: assert property ((!cs_n && sclk && $past(sclk)) |-> $stable(miso))
    else $error("device bit select moved while clock high");
  a_read_tail_zero: assert property ((s_frame_end ##0 cmd_r[OP_MSB:OP_LSB] == OP_READ) |->
    cmd_r[DATA_MSB:0] == 8'h00)
    else $error("read request with nonzero low byte");
  a_angle_gap_min: assert property (s_frame_end |=> cs_n)
    else $error("deselect gap too short");
  a_reg_gap_min: assert property (s_reg_end |-> cs_n [*8])
    else $error("idle after register frame too short");

  c_reg_frame: cover property (s_reg_end);
endmodule

// ---- asp_pkg.sv ----
package asp_pkg;
  // word layout of a command frame
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 5;
  localparam int DATA_W    = 8;
  localparam int OP_MSB    = 15;
  localparam int OP_LSB    = 13;
  localparam int ADDR_MSB  = 12;
  localparam int ADDR_LSB  = 8;
  localparam int DATA_MSB  = 7;
  localparam int REG_COUNT = 32;
  localparam logic [2:0] OP_READ  = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h4;

  // register numbers and fields
  localparam logic [ADDR_W-1:0] ADDR_DIR   = 5'h09;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 5'h1b;
  localparam logic [ADDR_W-1:0] ADDR_PPT_LO = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_PPT_HI = 5'h05;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 5'h06;
  localparam int DIR_BIT        = 7;
  localparam int FLAG_HIGH_BIT  = 7;
  localparam int FLAG_LOW_BIT   = 6;
  localparam logic [REG_COUNT-1:0] WRITABLE_MASK = 32'h0000027f;

  // factory contents of the non-volatile store
  localparam logic [DATA_W-1:0] DEF_ZERO    = 8'h00;
  localparam logic [DATA_W-1:0] DEF_PPT_LO  = 8'hc0;
  localparam logic [DATA_W-1:0] DEF_PPT_HI  = 8'hff;
  localparam logic [DATA_W-1:0] DEF_THRESH  = 8'h1c;

  // timing
  localparam int CLK_PERIOD_NS   = 100;
  localparam int T_SCLK_MIN_NS   = 40;
  localparam int T_REFRESH_NS    = 1000;
  localparam int T_IDLE_ANGLE_NS = 150;
  localparam int T_IDLE_REG_NS   = 750;
  localparam int T_NVM_MS        = 20;
  localparam int REFRESH_CYC     = T_REFRESH_NS / CLK_PERIOD_NS;
  localparam int IDLE_ANGLE_CYC  = (T_IDLE_ANGLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_REG_CYC    = (T_IDLE_REG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NVM_CYC         = (T_NVM_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_HALF_MIN   = (T_SCLK_MIN_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ANGLE_BITS      = 14;

  // operations a host user may request
  typedef enum logic [1:0] {
    ASP_OP_ANGLE = 2'h0,
    ASP_OP_READ  = 2'h1,
    ASP_OP_WRITE = 2'h2
  } asp_op_t;
endpackage

// ---- asp_spi_dev.sv ----
// Function
// - accepts clock modes 0 and 3 automatically
// - master clock at most 25 MHz, no minimum
// - every command frame is sixteen bits
// - sample on rising edge, change on falling
// - words travel most significant bit first
// - angle refresh every microsecond, frozen while selected
// - angle read: zeros in, sixteen angle bits out
// - unused low angle bits returned as zero
// - fast repeated reads return the same angle
// - at least 150 ns deselect between angle frames
// - at least 750 ns idle around register frames
// - read request: opcode 010, address, eight zeros
// - read reply carries register in upper byte
// - write request: opcode 100, address, value
// - write reply echoes the newly stored value
// - master waits 20 ms after write request
// - early second frame returns the old value
// - long wait only needed after write requests
// - registers persist and reload at power-up; here reset reloads the factory contents
// - register 27 holds field high/low flags
// - register 9 bit 7 selects counterclockwise rotation
module asp_spi_dev
  import asp_pkg::*;
#(
  parameter int ANGLE_RES = ANGLE_BITS, // useful angle bits
  parameter int NVM_WAIT  = NVM_CYC     // non-volatile update time in cycles
) (
  input  wire logic              I_SYS_CLK,     // internal clock
  input  wire logic              I_RST_B,       // reset, active low; sync in the system domain, async for cmd_r and cmd_tgl_r
  input  wire logic [WORD_W-1:0] I_ANGLE,       // angle from the front-end
  input  wire logic              I_FIELD_HIGH,  // field_high_flag
  input  wire logic              I_FIELD_LOW,   // field_low_flag
  output logic                   O_DIR_CCW,     // rotation direction setting
  asp_spi_if.dev                 LINK           // serial pins
);
  localparam int CNT_W = $clog2(NVM_WAIT + 1);
  localparam int REF_W = $clog2(REFRESH_CYC + 1);
  localparam logic [WORD_W-1:0] ANGLE_MASK = WORD_W'({WORD_W{1'b1}} << (WORD_W - ANGLE_RES));

  // link-domain state
  logic [4:0]        rise_cnt_r;
  logic [WORD_W-1:0] rx_sh_r;
  logic [WORD_W-1:0] cmd_r;
  logic              cmd_tgl_r;
  logic [3:0]        fall_cnt_r;

  // system-domain state
  logic              cs_s1_r;
  logic              cs_s2_r;
  logic              tgl_s1_r;
  logic              tgl_s2_r;
  logic              tgl_d_r;
  logic [REF_W-1:0]  ref_cnt_r;
  logic [WORD_W-1:0] angle_r;
  logic [WORD_W-1:0] tx_r;
  logic              resp_mode_r;
  logic [ADDR_W-1:0] resp_addr_r;
  logic [DATA_W-1:0] resp_byte_r;
  logic              pend_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic [DATA_W-1:0] pend_data_r;
  logic [CNT_W-1:0]  nvm_cnt_r;
  logic [DATA_W-1:0] nvm_r [0:REG_COUNT-1];

  logic              cmd_evt;
  logic              nvm_done;
  logic [2:0]        cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic [DATA_W-1:0] rd_val;

  // contents of the store before anything was ever written
  function automatic logic [DATA_W-1:0] factory_value(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_PPT_LO: factory_value = DEF_PPT_LO;
      ADDR_PPT_HI: factory_value = DEF_PPT_HI;
      ADDR_THRESH: factory_value = DEF_THRESH;
      default:     factory_value = DEF_ZERO;
    endcase
  endfunction

  // receive shifter; deselect clears it so each frame starts clean
  always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n) begin
      rise_cnt_r <= '0;
      rx_sh_r    <= '0;
    end else begin
      rx_sh_r <= {rx_sh_r[WORD_W-2:0], LINK.mosi};
      if (rise_cnt_r != 5'h10)
        rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  // only the sixteenth rising edge completes a command; extra clocks are ignored
  always_ff @(posedge LINK.sclk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cmd_r     <= '0;
      cmd_tgl_r <= 1'b0;
    end else if (!LINK.cs_n && rise_cnt_r == 5'h0f) begin
      cmd_r     <= {rx_sh_r[WORD_W-2:0], LINK.mosi};
      cmd_tgl_r <= ~cmd_tgl_r;
    end
  end

  // a falling edge before any rising edge is the mode 3 lead-in, not a shift
  always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
    if (LINK.cs_n)
      fall_cnt_r <= '0;
    else if (rise_cnt_r != 5'h00)
      fall_cnt_r <= fall_cnt_r + 4'h1;
  end

  // bit select from the frozen word, msb first
  assign LINK.miso      = tx_r[4'hf - fall_cnt_r];
  assign LINK.miso_oe_n = LINK.cs_n;

  // select and command toggle cross into the system clock
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      cs_s1_r  <= 1'b1;
      cs_s2_r  <= 1'b1;
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r  <= 1'b0;
    end else begin
      cs_s1_r  <= LINK.cs_n;
      cs_s2_r  <= cs_s1_r;
      tgl_s1_r <= cmd_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r  <= tgl_s2_r;
    end
  end

  // cmd_r holds still for the whole idle time that follows a frame
  assign cmd_evt  = tgl_s2_r ^ tgl_d_r;
  assign cmd_op   = cmd_r[OP_MSB:OP_LSB];
  assign cmd_addr = cmd_r[ADDR_MSB:ADDR_LSB];
  assign cmd_data = cmd_r[DATA_MSB:0];
  assign nvm_done = pend_r && (nvm_cnt_r == '0);

  // register read mux; a commit in this very cycle is already visible
  always_comb begin
    rd_val = '0;
    if (cmd_addr == ADDR_FLAGS) begin
      rd_val[FLAG_HIGH_BIT] = I_FIELD_HIGH;
      rd_val[FLAG_LOW_BIT]  = I_FIELD_LOW;
    end else if (WRITABLE_MASK[cmd_addr]) begin
      rd_val = (nvm_done && pend_addr_r == cmd_addr) ? pend_data_r : nvm_r[cmd_addr];
    end
  end

  // angle sample every refresh period, low bits beyond resolution zeroed
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      ref_cnt_r <= '0;
      angle_r   <= '0;
    end else if (ref_cnt_r == REF_W'(REFRESH_CYC - 1)) begin
      ref_cnt_r <= '0;
      angle_r   <= I_ANGLE & ANGLE_MASK;
    end else begin
      ref_cnt_r <= ref_cnt_r + 1'b1;
    end
  end

  // output word only moves while deselected, so a frame sees one value
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B)
      tx_r <= '0;
    else if (cs_s2_r)
      tx_r <= resp_mode_r ? {resp_byte_r, 8'h00} : angle_r;
  end

  // reply selection made by each completed command
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      resp_mode_r <= 1'b0;
      resp_addr_r <= '0;
      resp_byte_r <= '0;
    end else if (cmd_evt) begin
      resp_addr_r <= cmd_addr;
      resp_byte_r <= rd_val;
      case (cmd_op)
        OP_READ:  resp_mode_r <= 1'b1;
        OP_WRITE: resp_mode_r <= 1'b1;
        default:  resp_mode_r <= 1'b0;
      endcase
    end else if (nvm_done && resp_mode_r && resp_addr_r == pend_addr_r) begin
      resp_byte_r <= pend_data_r;
    end
  end

  // write request to a writable register starts the slow store update; another write meanwhile is dropped
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      pend_r      <= 1'b0;
      pend_addr_r <= '0;
      pend_data_r <= '0;
      nvm_cnt_r   <= '0;
    end else if (cmd_evt && cmd_op == OP_WRITE && WRITABLE_MASK[cmd_addr] && !pend_r) begin
      pend_r      <= 1'b1;
      pend_addr_r <= cmd_addr;
      pend_data_r <= cmd_data;
      nvm_cnt_r   <= CNT_W'(NVM_WAIT - 1);
    end else if (nvm_done) begin
      pend_r <= 1'b0;
    end else if (pend_r) begin
      nvm_cnt_r <= nvm_cnt_r - 1'b1;
    end
  end

  // store; reset reloads the factory contents, so written values do not survive it
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      for (int i = 0; i < REG_COUNT; i++)
        nvm_r[i] <= factory_value(ADDR_W'(i));
    end else if (nvm_done) begin
      nvm_r[pend_addr_r] <= pend_data_r;
    end
  end

  assign O_DIR_CCW = nvm_r[ADDR_DIR][DIR_BIT];
endmodule

// ---- asp_spi_host.sv ----
module asp_spi_host
  import asp_pkg::*;
#(
  parameter int SCLK_HALF = 4,       // system cycles per half serial clock
  parameter bit MODE3     = 1'b0,    // 1: clock idles high
  parameter int NVM_WAIT  = NVM_CYC  // wait after a write request
) (
  input  wire logic                I_SYS_CLK,  // system clock
  input  wire logic                I_RST_B,    // sync reset, active low
  input  wire logic                I_START,    // request pulse
  input  wire asp_op_t             I_OP,       // angle, read or write
  input  wire logic [ADDR_W-1:0]   I_ADDR,     // register number
  input  wire logic [DATA_W-1:0]   I_WDATA,    // value to write
  output logic                     O_BUSY,     // operation in progress
  output logic                     O_DONE,     // one-cycle completion pulse
  output logic [WORD_W-1:0]        O_RDATA,    // last frame's received word
  asp_spi_if.host                  LINK        // serial pins
);
  // counter must hold the longest wait it loads, even when the store wait is set short
  localparam int CNT_MAX = (NVM_WAIT > IDLE_REG_CYC) ? NVM_WAIT : IDLE_REG_CYC;
  localparam int CNT_W   = $clog2(((CNT_MAX > SCLK_HALF) ? CNT_MAX : SCLK_HALF) + 1);

  typedef enum logic [5:0] {
    H_IDLE  = 6'h01,
    H_SETUP = 6'h02,
    H_LO    = 6'h04,
    H_HI    = 6'h08,
    H_TAIL  = 6'h10,
    H_GAP   = 6'h20
  } asp_hstate_t;

  asp_hstate_t       state_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [3:0]        bit_r;
  logic              frame_r;
  logic              pre_r;
  asp_op_t           op_r;
  logic [WORD_W-1:0] tx_r;
  logic [WORD_W-1:0] rx_r;
  logic              miso_s1_r;
  logic              miso_s2_r;
  logic              cs_n_r;
  logic              sclk_r;
  logic              mosi_r;
  logic              done_r;
  logic [WORD_W-1:0] rdata_r;

  // idle time after a frame depends on what it was
  function automatic logic [CNT_W-1:0] gap_len(input asp_op_t op, input logic frame);
    if (op == ASP_OP_ANGLE)
      gap_len = CNT_W'(IDLE_ANGLE_CYC);
    else if (op == ASP_OP_WRITE && !frame)
      gap_len = CNT_W'(NVM_WAIT);
    else
      gap_len = CNT_W'(IDLE_REG_CYC);
  endfunction

  // data-in comes from another clock's logic
  always_ff @(posedge I_SYS_CLK) begin
    miso_s1_r <= LINK.miso_line;
    miso_s2_r <= miso_s1_r;
  end

  // frame sequencer; serial clock is a divided system clock
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_B) begin
      state_r <= H_IDLE;
      cnt_r   <= '0;
      bit_r   <= '0;
      frame_r <= 1'b0;
      pre_r   <= 1'b0;
      op_r    <= ASP_OP_ANGLE;
      tx_r    <= '0;
      rx_r    <= '0;
      cs_n_r  <= 1'b1;
      sclk_r  <= MODE3;
      mosi_r  <= 1'b0;
      done_r  <= 1'b0;
      rdata_r <= '0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        H_IDLE: begin
          if (I_START) begin
            op_r    <= I_OP;
            frame_r <= 1'b0;
            case (I_OP)
              ASP_OP_READ:  tx_r <= {OP_READ, I_ADDR, 8'h00};
              ASP_OP_WRITE: tx_r <= {OP_WRITE, I_ADDR, I_WDATA};
              default:      tx_r <= '0;
            endcase
            if (I_OP == ASP_OP_ANGLE) begin
              state_r <= H_SETUP;
              cnt_r   <= CNT_W'(SCLK_HALF - 1);
            end else begin
              // register access waits the long idle first
              state_r <= H_GAP;
              pre_r   <= 1'b1;
              cnt_r   <= CNT_W'(IDLE_REG_CYC);
            end
          end
        end
        H_SETUP: begin
          cs_n_r <= 1'b0;
          sclk_r <= MODE3;
          mosi_r <= tx_r[OP_MSB];
          bit_r  <= '0;
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= H_LO;
            cnt_r   <= CNT_W'(SCLK_HALF - 1);
          end
        end
        H_LO: begin
          sclk_r <= 1'b0;
          mosi_r <= tx_r[4'hf - bit_r];
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            state_r <= H_HI;
            cnt_r   <= CNT_W'(SCLK_HALF - 1);
          end
        end
        H_HI: begin
          sclk_r <= 1'b1;
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            // sample late in the high phase, past the synchroniser
            rx_r <= {rx_r[WORD_W-2:0], miso_s2_r};
            cnt_r <= CNT_W'(SCLK_HALF - 1);
            if (bit_r == 4'hf) begin
              state_r <= H_TAIL;
            end else begin
              bit_r   <= bit_r + 4'h1;
              state_r <= H_LO;
            end
          end
        end
        H_TAIL: begin
          sclk_r <= MODE3;
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else begin
            cs_n_r  <= 1'b1;
            rdata_r <= rx_r;
            state_r <= H_GAP;
            cnt_r   <= gap_len(op_r, frame_r);
          end
        end
        H_GAP: begin
          if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
          end else if (pre_r) begin
            pre_r   <= 1'b0;
            state_r <= H_SETUP;
            cnt_r   <= CNT_W'(SCLK_HALF - 1);
          end else if (op_r != ASP_OP_ANGLE && !frame_r) begin
            frame_r <= 1'b1;
            tx_r    <= '0;
            state_r <= H_SETUP;
            cnt_r   <= CNT_W'(SCLK_HALF - 1);
          end else begin
            done_r  <= 1'b1;
            state_r <= H_IDLE;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  assign LINK.cs_n = cs_n_r;
  assign LINK.sclk = sclk_r;
  assign LINK.mosi = mosi_r;
  assign O_BUSY    = (state_r != H_IDLE);
  assign O_DONE    = done_r;
  assign O_RDATA   = rdata_r;
endmodule

// ---- asp_spi_if.sv ----
interface asp_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe_n;
  logic miso_line;

  // the data-out pin sinks to low through its pull-down while released
  assign miso_line = miso_oe_n ? 1'b0 : miso;

  modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe_n);
  modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface
